// ==== verilog/cmosc_pkg.sv ====
// Package of constants and types for the clock mode and oscillation stabilization block.
package cmosc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CMOSC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CMOSC_ADDR_STBY = 8'h04;
  localparam logic [7:0] CMOSC_ADDR_STAT = 8'h08;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CMOSC_SPEED_LSB = 0;
  localparam int CMOSC_SELECT_BIT = 2;
  localparam int CMOSC_WAIT_LSB = 3;
  localparam int CMOSC_MONITOR_BIT = 7;

  // Standby request codes written to the standby register.
  localparam logic [2:0] CMOSC_REQ_SLEEP = 3'h1;
  localparam logic [2:0] CMOSC_REQ_STOP = 3'h2;
  localparam logic [2:0] CMOSC_REQ_WATCH = 3'h4;

  // Status register fields.
  localparam int CMOSC_STAT_MODE_LSB = 0;
  localparam int CMOSC_STAT_HOLD_BIT = 4;
  localparam int CMOSC_STAT_SUBSTAB_BIT = 5;

  // ****************************************************************
  // Speed codes and divider width
  // ****************************************************************
  localparam logic [1:0] CMOSC_SPEED_DIV4 = 2'h3;
  localparam logic [1:0] CMOSC_SPEED_DIV8 = 2'h2;
  localparam logic [1:0] CMOSC_SPEED_DIV16 = 2'h1;
  localparam logic [1:0] CMOSC_SPEED_DIV64 = 2'h0;
  localparam int CMOSC_DIV_W = 6;

  // ****************************************************************
  // Stabilization counters
  // ****************************************************************
  // Timebase overflow bits selected by the wait field.
  localparam int CMOSC_TB_W = 18;
  localparam int CMOSC_TB_BIT0 = 3;
  localparam int CMOSC_TB_BIT1 = 12;
  localparam int CMOSC_TB_BIT2 = 16;
  localparam int CMOSC_TB_BIT3 = 17;
  // Watch prescaler overflow at 2^15 subclock periods.
  localparam int CMOSC_WP_W = 16;
  localparam int CMOSC_WP_OVF_BIT = 15;

  // Reset value of the wait field, fixed by a manufacturing option.
  localparam logic [1:0] CMOSC_WAIT_RESET = 2'h3;

  typedef enum logic [2:0] {
    CMOSC_ST_MAIN_RUN = 3'h0,
    CMOSC_ST_MAIN_WAIT = 3'h1,
    CMOSC_ST_SUB_RUN = 3'h3,
    CMOSC_ST_SUB_WAIT = 3'h2,
    CMOSC_ST_MAIN_SLEEP = 3'h4,
    CMOSC_ST_MAIN_STOP = 3'h5,
    CMOSC_ST_SUB_SLEEP = 3'h7,
    CMOSC_ST_SUB_STOP = 3'h6
  } cmosc_state_t;

  localparam cmosc_state_t CMOSC_ST_WATCH = cmosc_state_t'(3'h2);

endpackage : cmosc_pkg

// ==== verilog/cmosc_sync.sv ====
// Two-flop synchroniser for an input from outside the clock domain.
`timescale 1ns/1ps
module cmosc_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } cmosc_sync_t;

  cmosc_sync_t st_r;
  cmosc_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : cmosc_sync

// ==== verilog/cmosc_ctrl.sv ====
// Clock mode controller with speed-shift divider and oscillation stabilization gating.
`timescale 1ns/1ps

// Contract
// - Main mode or subclock-only mode.
// - Speed field picks divide 4/8/16/64.
// - Speed clock feeds CPU; timers unaffected.
// - Main-run keeps both oscillators running.
// - Any reset starts in main-run.
// - Select 0 moves to subclock; monitor reports.
// - Subclock mode halts main oscillator, timebase.
// - Standby target depends on clock mode.
// - Select 1 requests main after wait.
// - Reset from subclock inserts delay per option.
// - Clock withheld until delay elapses.
// - Main delay is timebase overflow bit.
// - Wait delay for stop wake and switch.
// - Wait field reset value is an option.
// - Sub-stop wake waits 2^15 subclock periods.
// - Sub delay is watch prescaler overflow.
// - Monitor 0 on subclock, 1 on main.
// - Wait field selects four main delays.
module cmosc_ctrl #(
  parameter logic HAS_POR_OPTION = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic ext_irq,
  input wire logic periph_irq,
  input wire logic reset_soft_or_wdt,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic timebase_clk_en,
  output logic watch_clk_en,
  output logic main_osc_enable,
  output logic sub_osc_enable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    cmosc_pkg::cmosc_state_t mode;
    logic [1:0] speed;
    logic clock_source_select;
    logic [1:0] stab_wait;
    logic active_clock_monitor;
    logic [cmosc_pkg::CMOSC_DIV_W-1:0] div;
    logic [cmosc_pkg::CMOSC_TB_W-1:0] tb;
    logic [cmosc_pkg::CMOSC_WP_W-1:0] wp;
    logic sub_stab;
    logic boot;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpu_en;
    logic per_en;
    logic tb_en;
    logic wp_en;
  } cmosc_ctrl_t;

  cmosc_ctrl_t st_r;
  cmosc_ctrl_t st_nxt;

  logic main_tick_s;
  logic sub_tick_s;
  logic ext_irq_s;

  cmosc_sync u_sync_main (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .d(main_osc_tick), .q(main_tick_s)
  );
  cmosc_sync u_sync_sub (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .d(sub_osc_tick), .q(sub_tick_s)
  );
  cmosc_sync u_sync_irq (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .d(ext_irq), .q(ext_irq_s)
  );

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  // Terminal count of the speed divider for a speed code.
  function automatic logic [cmosc_pkg::CMOSC_DIV_W-1:0] div_last(input logic [1:0] sp);
    logic [cmosc_pkg::CMOSC_DIV_W-1:0] r;
    r = '0;
    unique case (sp)
      cmosc_pkg::CMOSC_SPEED_DIV4: r = 6'h03;
      cmosc_pkg::CMOSC_SPEED_DIV8: r = 6'h07;
      cmosc_pkg::CMOSC_SPEED_DIV16: r = 6'h0f;
      cmosc_pkg::CMOSC_SPEED_DIV64: r = 6'h3f;
    endcase
    return r;
  endfunction : div_last

  // Timebase overflow test at the bit chosen by the wait field.
  // four wait delays
  function automatic logic tb_done(input logic [1:0] wt,
                                   input logic [cmosc_pkg::CMOSC_TB_W-1:0] tb);
    logic r;
    r = 1'b0;
    unique case (wt)
      2'h0: r = tb[cmosc_pkg::CMOSC_TB_BIT0];
      2'h1: r = tb[cmosc_pkg::CMOSC_TB_BIT1];
      2'h2: r = tb[cmosc_pkg::CMOSC_TB_BIT2];
      2'h3: r = tb[cmosc_pkg::CMOSC_TB_BIT3];
    endcase
    return r;
  endfunction : tb_done

  function automatic logic on_sub(input cmosc_pkg::cmosc_state_t m);
    return m == cmosc_pkg::CMOSC_ST_SUB_RUN || m == cmosc_pkg::CMOSC_ST_SUB_SLEEP ||
           m == cmosc_pkg::CMOSC_ST_SUB_STOP || m == cmosc_pkg::CMOSC_ST_SUB_WAIT ||
           m == cmosc_pkg::CMOSC_ST_MAIN_WAIT;
  endfunction : on_sub

  logic wr_fire;
  logic rd_fire;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_fire = s_axi_arvalid && !st_r.rvalid;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[cmosc_pkg::CMOSC_SPEED_LSB +: 2] = st_r.speed;
    ctrl_word[cmosc_pkg::CMOSC_SELECT_BIT] = st_r.clock_source_select;
    ctrl_word[cmosc_pkg::CMOSC_WAIT_LSB +: 2] = st_r.stab_wait;
    ctrl_word[cmosc_pkg::CMOSC_MONITOR_BIT] = st_r.active_clock_monitor;
    stat_word = '0;
    stat_word[cmosc_pkg::CMOSC_STAT_MODE_LSB +: 3] = st_r.mode;
    stat_word[cmosc_pkg::CMOSC_STAT_HOLD_BIT] = !st_r.cpu_en;
    stat_word[cmosc_pkg::CMOSC_STAT_SUBSTAB_BIT] = st_r.sub_stab;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [2:0] req;
    logic div_wrap;
    logic tb_run;
    logic wp_run;
    req = '0;
    div_wrap = 1'b0;
    tb_run = 1'b0;
    wp_run = 1'b0;
    st_nxt = st_r;
    if (ce) begin
      // Bus write channels are taken in either order.
      if (s_axi_awvalid && !st_r.aw_got) begin
        st_nxt.aw_got = 1'b1;
        st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_got) begin
        st_nxt.w_got = 1'b1;
        st_nxt.w_data = s_axi_wdata;
        st_nxt.w_strb = s_axi_wstrb;
      end
      if (st_r.bvalid && s_axi_bready) begin
        st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
        st_nxt.rvalid = 1'b0;
      end
      if (rd_fire) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rresp = 2'h0;
        unique case (s_axi_araddr)
          cmosc_pkg::CMOSC_ADDR_CTRL: st_nxt.rdata = ctrl_word;
          cmosc_pkg::CMOSC_ADDR_STBY: st_nxt.rdata = '0;
          cmosc_pkg::CMOSC_ADDR_STAT: st_nxt.rdata = stat_word;
          default: begin
            st_nxt.rdata = '0;
            st_nxt.rresp = 2'h2;
          end
        endcase
      end

      div_wrap = st_r.div >= div_last(st_r.speed);
      tb_run = main_tick_s && !on_sub(st_r.mode) && st_r.mode != cmosc_pkg::CMOSC_ST_MAIN_STOP
               && st_r.mode != cmosc_pkg::CMOSC_ST_SUB_WAIT;
      tb_run = tb_run || (main_tick_s && st_r.mode == cmosc_pkg::CMOSC_ST_MAIN_WAIT);
      wp_run = sub_tick_s && st_r.mode != cmosc_pkg::CMOSC_ST_SUB_STOP;
      if (main_tick_s) begin
        st_nxt.div = div_wrap ? '0 : st_r.div + 6'h01;
      end
      if (tb_run) begin
        st_nxt.tb = st_r.tb + 18'h00001;
      end
      if (wp_run) begin
        st_nxt.wp = st_r.wp + 16'h0001;
        if (st_r.wp[cmosc_pkg::CMOSC_WP_OVF_BIT]) begin
          st_nxt.sub_stab = 1'b0;
        end
      end

      if (wr_fire) begin
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got = 1'b0;
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp = 2'h0;
        if (st_r.aw_addr == cmosc_pkg::CMOSC_ADDR_CTRL && st_r.w_strb[0]) begin
          st_nxt.speed = st_r.w_data[cmosc_pkg::CMOSC_SPEED_LSB +: 2];
          if (st_r.mode != cmosc_pkg::CMOSC_ST_MAIN_WAIT) begin
            st_nxt.stab_wait = st_r.w_data[cmosc_pkg::CMOSC_WAIT_LSB +: 2];
          end
          st_nxt.clock_source_select = st_r.w_data[cmosc_pkg::CMOSC_SELECT_BIT];
        end else if (st_r.aw_addr == cmosc_pkg::CMOSC_ADDR_STBY && st_r.w_strb[0]) begin
          req = st_r.w_data[2:0];
        end else if (st_r.aw_addr != cmosc_pkg::CMOSC_ADDR_STAT) begin
          st_nxt.bresp = 2'h2;
        end
      end

      unique case (st_r.mode)
        cmosc_pkg::CMOSC_ST_MAIN_RUN: begin
          if (wr_fire && st_nxt.clock_source_select == 1'b0 &&
              st_r.aw_addr == cmosc_pkg::CMOSC_ADDR_CTRL) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_RUN;
          end else if (req == cmosc_pkg::CMOSC_REQ_SLEEP && !periph_irq) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_MAIN_SLEEP;
          end else if (req == cmosc_pkg::CMOSC_REQ_STOP && !periph_irq) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_MAIN_STOP;
          end
        end
        cmosc_pkg::CMOSC_ST_SUB_RUN: begin
          if (wr_fire && st_nxt.clock_source_select &&
              st_r.aw_addr == cmosc_pkg::CMOSC_ADDR_CTRL) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_MAIN_WAIT;
            st_nxt.tb = '0;
          end else if (req == cmosc_pkg::CMOSC_REQ_SLEEP && !periph_irq) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_SLEEP;
          end else if (req == cmosc_pkg::CMOSC_REQ_STOP && !periph_irq) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_STOP;
          end else if (req == cmosc_pkg::CMOSC_REQ_WATCH && !periph_irq) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_WAIT;
          end
        end
        cmosc_pkg::CMOSC_ST_MAIN_WAIT: begin
          if (tb_done(st_r.stab_wait, st_r.tb)) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_MAIN_RUN;
          end
        end
        cmosc_pkg::CMOSC_ST_SUB_WAIT: begin
          if (ext_irq_s || periph_irq) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_RUN;
          end
        end
        cmosc_pkg::CMOSC_ST_MAIN_SLEEP: begin
          if (periph_irq || ext_irq_s) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_MAIN_RUN;
          end
        end
        cmosc_pkg::CMOSC_ST_SUB_SLEEP: begin
          if (periph_irq || ext_irq_s) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_RUN;
          end
        end
        cmosc_pkg::CMOSC_ST_MAIN_STOP: begin
          if (ext_irq_s) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_MAIN_WAIT;
            st_nxt.tb = '0;
          end
        end
        cmosc_pkg::CMOSC_ST_SUB_STOP: begin
          if (ext_irq_s) begin
            st_nxt.mode = cmosc_pkg::CMOSC_ST_SUB_RUN;
            st_nxt.wp = '0;
            st_nxt.sub_stab = 1'b1;
          end
        end
      endcase

      st_nxt.active_clock_monitor = !on_sub(st_nxt.mode) &&
                                    st_nxt.mode != cmosc_pkg::CMOSC_ST_SUB_WAIT;
      st_nxt.cpu_en = (st_nxt.mode == cmosc_pkg::CMOSC_ST_MAIN_RUN && main_tick_s &&
                       st_nxt.div == '0) ||
                      (st_nxt.mode == cmosc_pkg::CMOSC_ST_SUB_RUN && sub_tick_s &&
                       !st_nxt.sub_stab);
      st_nxt.per_en = st_nxt.cpu_en ||
                      (st_nxt.mode == cmosc_pkg::CMOSC_ST_MAIN_SLEEP && main_tick_s &&
                       st_nxt.div == '0) ||
                      (st_nxt.mode == cmosc_pkg::CMOSC_ST_SUB_SLEEP && sub_tick_s);
      st_nxt.tb_en = tb_run;
      st_nxt.wp_en = wp_run;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.mode <= cmosc_pkg::CMOSC_ST_MAIN_RUN;
      st_r.speed <= cmosc_pkg::CMOSC_SPEED_DIV64;
      st_r.clock_source_select <= 1'b1;
      st_r.stab_wait <= cmosc_pkg::CMOSC_WAIT_RESET;
      st_r.boot <= 1'b1;
      st_r.sub_stab <= 1'b1;
    end else if (st_r.boot && ce) begin
      st_r.boot <= 1'b0;
      if (HAS_POR_OPTION || reset_soft_or_wdt) begin
        st_r.mode <= cmosc_pkg::CMOSC_ST_MAIN_WAIT;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = !st_r.aw_got && !st_r.boot;
  assign s_axi_wready = !st_r.w_got && !st_r.boot;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid && !st_r.boot;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign cpu_clk_en = st_r.cpu_en;
  assign periph_clk_en = st_r.per_en;
  assign timebase_clk_en = st_r.tb_en;
  assign watch_clk_en = st_r.wp_en;
  assign main_osc_enable = (!on_sub(st_r.mode) && st_r.mode != cmosc_pkg::CMOSC_ST_MAIN_STOP) ||
                           st_r.mode == cmosc_pkg::CMOSC_ST_MAIN_WAIT;
  assign sub_osc_enable = st_r.mode != cmosc_pkg::CMOSC_ST_SUB_STOP;

endmodule : cmosc_ctrl

// ==== dv/cmosc_ctrl_asserts.sv ====
// Port checker for the clock mode and stabilization controller.
`timescale 1ns/1ps
module cmosc_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic timebase_clk_en,
  input wire logic watch_clk_en,
  input wire logic main_osc_enable,
  input wire logic sub_osc_enable
);
  // ****************************************************************
  // Clock gating and bus read properties
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_reset_main;
    $rose(aresetn) |-> main_osc_enable && sub_osc_enable;
  endproperty
  a_reset_main: assert property (p_reset_main) else $error("reset left main run");
  property p_tb_stop;
    !main_osc_enable [*4] |-> !timebase_clk_en;
  endproperty
  a_tb_stop: assert property (p_tb_stop) else $error("timebase ticks with main off");
  property p_hold;
    $rose(main_osc_enable) |=> (!cpu_clk_en && !periph_clk_en) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("clock given before delay");
  property p_speed_gap;
    main_osc_enable [*4] ##0 cpu_clk_en |->
      !$past(cpu_clk_en, 1) && !$past(cpu_clk_en, 2) && !$past(cpu_clk_en, 3);
  endproperty
  a_speed_gap: assert property (p_speed_gap) else $error("main clock too fast");
  property p_periph;
    cpu_clk_en |-> periph_clk_en;
  endproperty
  a_periph: assert property (p_periph) else $error("cpu clock without periph");
  property p_both_run;
    main_osc_enable |-> sub_osc_enable;
  endproperty
  a_both_run: assert property (p_both_run) else $error("subclock off in main");
  property p_watch_stop;
    !sub_osc_enable [*4] |-> !watch_clk_en;
  endproperty
  a_watch_stop: assert property (p_watch_stop) else $error("prescaler ticks with sub off");
  property p_sub_cpu;
    !main_osc_enable && cpu_clk_en |=> !cpu_clk_en;
  endproperty
  a_sub_cpu: assert property (p_sub_cpu) else $error("sub clock too fast");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  c_main_start: cover property ($rose(main_osc_enable));
  c_sub_stop: cover property ($fell(sub_osc_enable));
  c_sub_cpu: cover property (!main_osc_enable && cpu_clk_en);
endmodule : cmosc_ctrl_asserts

bind cmosc_ctrl cmosc_ctrl_asserts i_cmosc_ctrl_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .timebase_clk_en(timebase_clk_en),
  .watch_clk_en(watch_clk_en), .main_osc_enable(main_osc_enable),
  .sub_osc_enable(sub_osc_enable));

// ==== dv/tb_cmosc_ctrl.sv ====
// Self-checking bench for the clock mode and stabilization controller.
`timescale 1ns/1ps
module tb_cmosc_ctrl;
  // ****************************************************************
  // Signals and stimulus helpers
  // ****************************************************************
  localparam int DIV [4] = '{64, 16, 8, 4};
  localparam int MINW [2] = '{16, 8192};
  localparam logic [31:0] REQ [5] = '{32'h1, 32'h2, 32'h4, 32'h1, 32'h4};
  localparam logic SEL [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic [31:0] ENT [5] = '{32'h4, 32'h5, 32'h0, 32'h7, 32'h2};
  localparam logic [31:0] BACK [5] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h3};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic main_osc_tick = 1'b0;
  logic sub_osc_tick = 1'b0;
  logic ext_irq = 1'b0;
  logic periph_irq = 1'b0;
  logic reset_soft_or_wdt = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic cpu_clk_en, periph_clk_en, timebase_clk_en, watch_clk_en;
  logic main_osc_enable, sub_osc_enable;
  int failures = 0;
  int checks = 0;
  int cyc = 0;

  always #50 aclk = ~aclk;
  // Oscillator pulses run only while the controller keeps that oscillator on.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    main_osc_tick <= (main_osc_enable === 1'b1) & ~main_osc_tick;
    sub_osc_tick <= (sub_osc_enable === 1'b1) & ~sub_osc_tick;
  end

  cmosc_ctrl #(.HAS_POR_OPTION(1'b0)) i_cmosc_ctrl (.aclk, .aresetn, .ce(1'b1),
    .main_osc_tick, .sub_osc_tick, .ext_irq, .periph_irq, .reset_soft_or_wdt,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_clk_en, .periph_clk_en, .timebase_clk_en,
    .watch_clk_en, .main_osc_enable, .sub_osc_enable);

  function automatic logic [31:0] ctrl(input logic [1:0] s, input logic sel, input logic [1:0] w);
    return {27'h0, w, sel, s};
  endfunction : ctrl

  task automatic stop_test(input bit timed_out);
    if (timed_out) failures++;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_range(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h to %h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (!(aw_ok && w_ok)) stop_test(1);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) stop_test(1);
    check_val({30'h0, s_axi_bresp}, (a < 8'h0c) ? 32'h0 : 32'h2);
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    if (n >= 50) stop_test(1);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n >= 50) stop_test(1);
    check_val({30'h0, s_axi_rresp}, (a < 8'h0c) ? 32'h0 : 32'h2);
    @(posedge aclk);
  endtask : axi_read

  // Polls a register until the masked value matches, within a cycle limit.
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input int lim);
    int t0;
    t0 = cyc;
    do begin
      axi_read(a, rd);
    end while ((rd & m) !== e && cyc - t0 < lim);
    if ((rd & m) !== e) stop_test(1);
  endtask : wait_reg

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin : main_seq
    int cnt;
    int t0;
    int tbc [4];
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(8'h00, rd);
    check_val(rd & 32'h9f, 32'h9c);
    axi_read(8'h08, rd);
    check_val(rd & 32'h27, 32'h20);
    axi_write(8'h0c, 32'h0);
    axi_read(8'h0c, rd);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      axi_write(8'h00, ctrl(s[1:0], 1'b1, 2'h3));
      cnt = 0;
      tbc[s] = 0;
      repeat (512) begin
        @(posedge aclk);
        if (cpu_clk_en === 1'b1) cnt++;
        if (timebase_clk_en === 1'b1) tbc[s]++;
      end
      check_range(cnt, 256 / DIV[s] - 1, 256 / DIV[s] + 1);
      check_range(tbc[s], tbc[0] - 1, tbc[0] + 1);
    end
    $display("test speed done");
    wait_reg(8'h08, 32'h20, 32'h0, 70000);
    for (int w = 1; w >= 0; w--) begin
      axi_write(8'h00, ctrl(2'h3, 1'b1, w[1:0]));
      axi_write(8'h00, ctrl(2'h3, 1'b0, w[1:0]));
      axi_read(8'h00, rd);
      check_val(rd & 32'h9f, ctrl(2'h3, 1'b0, w[1:0]));
      axi_read(8'h08, rd);
      check_val(rd & 32'h07, 32'h3);
      check_val({30'h0, sub_osc_enable, main_osc_enable}, 32'h2);
      cnt = 0;
      repeat (64) begin
        @(posedge aclk);
        if (timebase_clk_en === 1'b1) cnt++;
      end
      check_range(cnt, 0, 0);
      axi_write(8'h00, ctrl(2'h3, 1'b1, w[1:0]));
      t0 = cyc;
      if (w == 1) begin
        axi_read(8'h08, rd);
        check_val(rd & 32'h17, 32'h11);
        axi_write(8'h00, ctrl(2'h3, 1'b1, 2'h0));
        axi_read(8'h00, rd);
        check_val(rd & 32'h9f, ctrl(2'h3, 1'b1, 2'h1));
      end
      wait_reg(8'h00, 32'h80, 32'h80, 40000);
      check_range(cyc - t0, MINW[w], 40000);
      cnt = 0;
      repeat (64) begin
        @(posedge aclk);
        if (cpu_clk_en === 1'b1) cnt++;
      end
      check_range(cnt, 7, 9);
    end
    $display("test clock switch done");
    for (int i = 0; i < 5; i++) begin
      axi_write(8'h00, ctrl(2'h3, SEL[i], 2'h0));
      wait_reg(8'h08, 32'h07, BACK[i], 200);
      axi_write(8'h04, REQ[i]);
      axi_read(8'h08, rd);
      check_val(rd & 32'h07, ENT[i]);
      check_val({31'h0, main_osc_enable}, {31'h0, ENT[i] == 32'h0 || ENT[i] == 32'h4});
      if (i == 1) ext_irq <= 1'b1;
      else periph_irq <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_irq <= 1'b0;
      periph_irq <= 1'b0;
      wait_reg(8'h08, 32'h07, BACK[i], 2000);
    end
    axi_write(8'h04, 32'h2);
    axi_read(8'h08, rd);
    check_val(rd & 32'h07, 32'h6);
    check_val({30'h0, sub_osc_enable, main_osc_enable}, 32'h0);
    ext_irq <= 1'b1;
    wait_reg(8'h08, 32'h37, 32'h33, 200);
    ext_irq <= 1'b0;
    $display("test standby done");
    for (int r = 0; r < 2; r++) begin
      reset_soft_or_wdt <= r[0];
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(8'h08, rd);
      check_val(rd & 32'h07, (r == 1) ? 32'h1 : 32'h0);
    end
    $display("test late reset done");
    stop_test(0);
  end
endmodule : tb_cmosc_ctrl
